//--- src/rps_regs.vh
// How it works
// - Per-channel four-entry synchronizer, word wide
// - Written on parallel strobe, read on tick
// - Write and read rates must match
// - FIFO has no flags; reads pause while the output is stalled
// - Word boundary not assumed; slips correct it
// - Realign parallel words, per channel control
// - Each slip rising edge shifts one bit
// - Realigner always in path, else latency only
// - Slip from fabric or synchronized pin
// - Word width selectable 8 or 10
// - Slip counter mixes the staging register with the FIFO output
// - New valid word two clocks after word tick
// - Bit clock is word clock times width
`ifndef RPS_REGS_VH
`define RPS_REGS_VH

`define RPS_WORD_W      10
`define RPS_CNT_W       4
`define RPS_PTR_W       2
`define RPS_FIFO_DEPTH  4
`define RPS_WPTR_RST    2'h2
`define RPS_RPTR_RST    2'h0
`define RPS_WIDTH_NARROW 4'h8
`define RPS_WIDTH_WIDE   4'hA
`define RPS_CNT_RST     4'h0
`define RPS_WORD_RST    10'h000

`endif

//--- src/rps_sync_fifo.v
`timescale 1ns/1ps
`include "rps_regs.vh"

module rps_sync_fifo (
  // Clock and reset
  input  wire                   clk_i,
  input  wire                   nrst_i,
  // Write side
  input  wire                   wr_stb_i,
  input  wire [`RPS_WORD_W-1:0] wr_data_i,
  // Read side
  input  wire                   rd_stb_i,
  output wire [`RPS_WORD_W-1:0] rd_data_o
);

  reg [`RPS_WORD_W-1:0] mem_r [0:`RPS_FIFO_DEPTH-1];
  reg [`RPS_PTR_W-1:0]  wptr_r;
  reg [`RPS_PTR_W-1:0]  rptr_r;

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wptr_r <= `RPS_WPTR_RST;
      rptr_r <= `RPS_RPTR_RST;
    end else begin
      if (wr_stb_i) begin
        wptr_r <= wptr_r + 2'h1;
      end
      if (rd_stb_i) begin
        rptr_r <= rptr_r + 2'h1;
      end
    end
  end

  always @(posedge clk_i) begin
    if (wr_stb_i) begin
      mem_r[wptr_r] <= wr_data_i;
    end
  end

  assign rd_data_o = mem_r[rptr_r];

endmodule

//--- src/rps_skid.v
`timescale 1ns/1ps
`include "rps_regs.vh"

module rps_skid (
  // Clock and reset
  input  wire                   clk_i,
  input  wire                   nrst_i,
  // Fill side
  input  wire                   in_vld_i,
  output wire                   in_rdy_o,
  input  wire [`RPS_WORD_W-1:0] in_data_i,
  // Drain side
  output wire                   out_vld_o,
  input  wire                   out_rdy_i,
  output wire [`RPS_WORD_W-1:0] out_data_o
);

  reg [`RPS_WORD_W-1:0] e0_r;
  reg [`RPS_WORD_W-1:0] e1_r;
  reg                   v0_r;
  reg                   v1_r;
  wire                  push;
  wire                  pop;

  assign push = in_vld_i & ~v1_r;
  assign pop  = v0_r & out_rdy_i;

  // Head entry always in e0 so the output is a plain flop
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      e0_r <= `RPS_WORD_RST;
      e1_r <= `RPS_WORD_RST;
      v0_r <= 1'b0;
      v1_r <= 1'b0;
    end else if (pop) begin
      if (v1_r) begin
        e0_r <= e1_r;
        if (push) begin
          e1_r <= in_data_i;
        end else begin
          v1_r <= 1'b0;
        end
      end else if (push) begin
        e0_r <= in_data_i;
      end else begin
        v0_r <= 1'b0;
      end
    end else if (push) begin
      if (!v0_r) begin
        e0_r <= in_data_i;
        v0_r <= 1'b1;
      end else begin
        e1_r <= in_data_i;
        v1_r <= 1'b1;
      end
    end
  end

  assign in_rdy_o   = ~v1_r;
  assign out_vld_o  = v0_r;
  assign out_data_o = e0_r;

endmodule

//--- src/rps_top.v
`timescale 1ns/1ps
`include "rps_regs.vh"

module rps_top (
  // Clock and reset
  input  wire                   clk_i,
  input  wire                   nrst_i,
  // Deserialized words
  input  wire                   par_stb_i,
  input  wire [`RPS_WORD_W-1:0] par_data_i,
  output wire                   par_rdy_o,
  // Configuration
  input  wire                   width_sel_i,
  input  wire                   slip_en_i,
  input  wire                   slip_src_sel_i,
  // Slip requests
  input  wire                   slip_fab_i,
  input  wire                   slip_pin_i,
  // Aligned words to fabric
  output wire [`RPS_WORD_W-1:0] word_o,
  output wire                   word_vld_o,
  input  wire                   word_rdy_i,
  // Status
  output wire [`RPS_CNT_W-1:0]  slip_cnt_o,
  output wire                   word_tick_o
);

  // Pick n bits starting cnt bits up in {older, newer}
  function [`RPS_WORD_W-1:0] rps_realign;
    input [`RPS_WORD_W-1:0] older;
    input [`RPS_WORD_W-1:0] newer;
    input [`RPS_CNT_W-1:0]  cnt;
    input                   wide;
    reg   [19:0]            cat;
    begin
      if (wide) begin
        cat = {older, newer} >> cnt;
        rps_realign = cat[9:0];
      end else begin
        cat = {4'h0, older[7:0], newer[7:0]} >> cnt;
        rps_realign = {2'h0, cat[7:0]};
      end
    end
  endfunction

  wire [`RPS_CNT_W-1:0]  width_n;
  wire [`RPS_CNT_W-1:0]  last_idx;
  wire [`RPS_WORD_W-1:0] fifo_q;
  wire                   skid_rdy;
  wire                   skid_vld;
  wire [`RPS_WORD_W-1:0] skid_q;
  wire                   slip_req;
  wire                   slip_rise;
  wire                   tick;
  wire                   rd_go;

  reg  [`RPS_CNT_W-1:0]  div_r;
  reg  [`RPS_CNT_W-1:0]  slip_cnt_r;
  reg  [`RPS_WORD_W-1:0] stage2_r;
  reg  [`RPS_WORD_W-1:0] stage3_r;
  reg  [`RPS_WORD_W-1:0] word_r;
  reg                    word_vld_r;
  reg                    pin_meta_r;
  reg                    pin_sync_r;
  reg                    slip_prev_r;
  reg                    par_rdy_r;
  reg                    tick_r;

  assign width_n  = width_sel_i ? `RPS_WIDTH_WIDE : `RPS_WIDTH_NARROW;
  assign last_idx = width_n - 4'h1;

  // one bit per clock, word tick every n bits
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_r <= `RPS_CNT_RST;
    end else if (div_r >= last_idx) begin
      div_r <= `RPS_CNT_RST;
    end else begin
      div_r <= div_r + 4'h1;
    end
  end

  assign tick  = (div_r == last_idx);
  // A stalled receiver holds the read side rather than lose a word
  assign rd_go = tick & skid_rdy;

  // strobe rate must equal tick rate
  rps_sync_fifo u_fifo (
    .clk_i     (clk_i),
    .nrst_i    (nrst_i),
    .wr_stb_i  (par_stb_i),
    .wr_data_i (par_data_i),
    .rd_stb_i  (rd_go),
    .rd_data_o (fifo_q)
  );

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_meta_r <= 1'b0;
      pin_sync_r <= 1'b0;
    end else begin
      pin_meta_r <= slip_pin_i;
      pin_sync_r <= pin_meta_r;
    end
  end

  // fabric request arrives retimed by its controller
  assign slip_req = slip_en_i & (slip_src_sel_i ? pin_sync_r : slip_fab_i);

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      slip_prev_r <= 1'b0;
    end else begin
      slip_prev_r <= slip_req;
    end
  end

  // a long low gap keeps one edge per pulse
  assign slip_rise = slip_req & ~slip_prev_r;

  // counter wraps past n-1 to 0
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      slip_cnt_r <= `RPS_CNT_RST;
    end else if (slip_cnt_r > last_idx) begin
      slip_cnt_r <= `RPS_CNT_RST;
    end else if (slip_rise) begin
      if (slip_cnt_r == last_idx) begin
        slip_cnt_r <= `RPS_CNT_RST;
      end else begin
        slip_cnt_r <= slip_cnt_r + 4'h1;
      end
    end
  end

  // staging keeps the previous word for boundary shifts
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stage2_r <= `RPS_WORD_RST;
      stage3_r <= `RPS_WORD_RST;
    end else if (rd_go) begin
      stage2_r <= stage3_r;
      stage3_r <= fifo_q;
    end
  end

  // count 0 passes the low n bits of the FIFO output unchanged
  // word valid on the clock after the shift
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      word_r     <= `RPS_WORD_RST;
      word_vld_r <= 1'b0;
    end else begin
      word_vld_r <= rd_go;
      if (rd_go) begin
        word_r <= rps_realign(stage3_r, fifo_q, slip_cnt_r, width_sel_i);
      end
    end
  end

  rps_skid u_skid (
    .clk_i      (clk_i),
    .nrst_i     (nrst_i),
    .in_vld_i   (word_vld_r),
    .in_rdy_o   (skid_rdy),
    .in_data_i  (word_r),
    .out_vld_o  (skid_vld),
    .out_rdy_i  (word_rdy_i),
    .out_data_o (skid_q)
  );

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      par_rdy_r <= 1'b0;
      tick_r    <= 1'b0;
    end else begin
      par_rdy_r <= skid_rdy;
      tick_r    <= rd_go;
    end
  end

  assign par_rdy_o   = par_rdy_r;
  assign word_o      = skid_q;
  assign word_vld_o  = skid_vld;
  assign slip_cnt_o  = slip_cnt_r;
  assign word_tick_o = tick_r;

endmodule

//--- testbench/rps_top_props.sv
`timescale 1ns/1ps
module rps_top_chk (
  input logic       clk_i,
  input logic       nrst_i,
  input logic       width_sel_i,
  input logic       slip_en_i,
  input logic       slip_src_sel_i,
  input logic       slip_fab_i,
  input logic [9:0] word_o,
  input logic       word_vld_o,
  input logic       word_rdy_i,
  input logic [3:0] slip_cnt_o,
  input logic       word_tick_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_fab_edge;
    slip_en_i && !slip_src_sel_i && $rose(slip_fab_i);
  endsequence
  sequence s_stalled;
    word_vld_o && !word_rdy_i;
  endsequence
  chk_cnt_range:
    assert property (slip_cnt_o < (width_sel_i ? 4'ha : 4'h8)) else $error("count range");
  chk_cnt_step:
    assert property (s_fab_edge |=> slip_cnt_o == (($past(slip_cnt_o) ==
      (width_sel_i ? 4'h9 : 4'h7)) ? 4'h0 : $past(slip_cnt_o) + 4'h1)) else $error("slip step");
  chk_slip_off:
    assert property (!slip_en_i && $past(!slip_en_i) |-> $stable(slip_cnt_o))
      else $error("slip while off");
  chk_high_once:
    assert property (!slip_src_sel_i && slip_fab_i && $past(slip_fab_i) |=> $stable(slip_cnt_o))
      else $error("slip on held level");
  chk_tick_space:
    assert property (word_tick_o |=> !word_tick_o [*7]) else $error("tick spacing");
  chk_tick_word:
    assert property (word_tick_o |=> word_vld_o) else $error("no word after tick");
  chk_stall_hold:
    assert property (s_stalled |=> word_vld_o && $stable(word_o)) else $error("word lost");
  chk_narrow_top:
    assert property (!width_sel_i |-> word_o[9:8] == 2'h0) else $error("narrow top bits");
endmodule
bind rps_top rps_top_chk u_chk (.clk_i, .nrst_i, .width_sel_i, .slip_en_i, .slip_src_sel_i,
  .slip_fab_i, .word_o, .word_vld_o, .word_rdy_i, .slip_cnt_o, .word_tick_o);

//--- testbench/rps_ctl_model.sv
`timescale 1ns/1ps
module rps_ctl_model (
  // Clock
  input  wire       clk_i,
  // Setup
  input  wire       wide_i,
  input  wire       use_pin_i,
  input  wire [9:0] pat_i,
  // Words and slip requests
  output reg        par_stb_o = 1'b0,
  output reg  [9:0] par_data_o = 10'h000,
  output reg        slip_fab_o = 1'b0,
  output reg        slip_pin_o = 1'b0
);
  int cnt = 0;
  int n = 10;
  always @(posedge clk_i) begin
    #1;
    n = wide_i ? 10 : 8;
    par_stb_o = (cnt == 0);
    // Off-strobe data inverted so stale captures show
    par_data_o = par_stb_o ? pat_i : ~pat_i;
    cnt = (cnt >= n - 1) ? 0 : cnt + 1;
  end
  // registered request, long high, long low
  task automatic pulse;
    begin
      @(posedge clk_i);
      #1;
      if (use_pin_i) slip_pin_o = 1'b1;
      else slip_fab_o = 1'b1;
      repeat (3 * n) @(posedge clk_i);
      #1;
      slip_fab_o = 1'b0;
      slip_pin_o = 1'b0;
      repeat (4 * n) @(posedge clk_i);
    end
  endtask
endmodule

//--- testbench/rps_top_bench.sv
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin n_mismatch++; \
  $display("MISMATCH %s exp %h got %h", nm, ex, gt); end end
module rps_top_bench;
  logic       clk_i = 0;
  logic       nrst_i = 0;
  logic       width_sel_i = 1;
  logic       slip_en_i = 0;
  logic       slip_src_sel_i = 0;
  logic       word_rdy_i = 1;
  logic [9:0] pat = 10'h2b5;
  wire        par_stb_i, slip_fab_i, slip_pin_i, par_rdy_o, word_vld_o, word_tick_o;
  wire  [9:0] par_data_i, word_o;
  wire  [3:0] slip_cnt_o;
  int         n_mismatch = 0;
  int         checks_done = 0;
  int         n = 10;
  int         slips = 0;
  rps_ctl_model u_ctl (.clk_i, .wide_i(width_sel_i), .use_pin_i(slip_src_sel_i), .pat_i(pat),
    .par_stb_o(par_stb_i), .par_data_o(par_data_i), .slip_fab_o(slip_fab_i),
    .slip_pin_o(slip_pin_i));
  rps_top u_dut (.clk_i, .nrst_i, .par_stb_i, .par_data_i, .par_rdy_o, .width_sel_i,
    .slip_en_i, .slip_src_sel_i, .slip_fab_i, .slip_pin_i, .word_o, .word_vld_o,
    .word_rdy_i, .slip_cnt_o, .word_tick_o);
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  function automatic logic [9:0] rot(input int k);
    logic [19:0] d;
    begin
      d = (n == 10) ? {pat, pat} : {4'h0, pat[7:0], pat[7:0]};
      d = d >> k;
      rot = (n == 10) ? d[9:0] : {2'h0, d[7:0]};
    end
  endfunction
  task automatic chk_word(input string nm);
    begin
      for (int i = 0; i < 40; i++) begin
        @(negedge clk_i);
        if (word_vld_o === 1'b1) break;
      end
      `CHK(nm, rot(slips % n), word_o)
      @(posedge clk_i);
    end
  endtask
  task automatic slip_chk(input string nm);
    begin
      u_ctl.pulse();
      slips++;
      chk_word(nm);
      `CHK("slip count", 4'(slips % n), slip_cnt_o)
    end
  endtask
  task automatic do_reset(input logic w);
    begin
      @(posedge clk_i);
      #1 nrst_i = 0;
      width_sel_i = w;
      slip_en_i = 0;
      slip_src_sel_i = 0;
      slips = 0;
      n = w ? 10 : 8;
      repeat (6) @(posedge clk_i);
      #1 nrst_i = 1;
      // First reads after reset are stale
      repeat (6 * n) @(posedge clk_i);
    end
  endtask
  task automatic t_latency;
    begin
      chk_word("plain word");
      u_ctl.pulse();
      chk_word("word, slip off");
      `CHK("count, slip off", 4'h0, slip_cnt_o)
    end
  endtask
  task automatic t_slips;
    begin
      @(posedge clk_i);
      #1 slip_en_i = 1;
      // Wraps past n-1 back to zero
      repeat (n + 1) slip_chk("fabric slip");
      #1 slip_src_sel_i = 1;
      slip_chk("pin slip");
    end
  endtask
  task automatic t_hunt;
    logic [9:0] seen_r;
    logic [9:0] target;
    int         tries;
    begin
      target = rot((slips + 3) % n);
      for (tries = 0; tries < n + 1; tries++) begin
        for (int i = 0; i < 40; i++) begin
          @(negedge clk_i);
          if (word_vld_o === 1'b1) break;
        end
        seen_r = word_o;
        @(posedge clk_i);
        if (seen_r === target) break;
        u_ctl.pulse();
        slips++;
      end
      `CHK("hunt word", target, seen_r)
      `CHK("hunt count", 4'(slips % n), slip_cnt_o)
    end
  endtask
  task automatic t_stall;
    begin
      @(posedge clk_i);
      #1 word_rdy_i = 0;
      repeat (4 * n) @(posedge clk_i);
      #1 `CHK("room while stalled", 1'b0, par_rdy_o)
      `CHK("held word", rot(slips % n), word_o)
      word_rdy_i = 1;
      chk_word("word after stall");
    end
  endtask
  task automatic conclude;
    begin
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  initial begin
    for (int w = 1; w >= 0; w--) begin
      do_reset(w[0]);
      t_latency;
      t_slips;
      t_hunt;
      t_stall;
    end
    conclude();
  end
  initial begin
    #400000;
    n_mismatch++;
    conclude();
  end
endmodule
